// ### core/bmp_pkg.sv
// types of the bus port: states, pin bundles and the module state record
package bmp_pkg;

	typedef enum logic [2:0] {
		BMP_IDLE = 3'h0,
		BMP_REQ = 3'h1,
		BMP_CYC = 3'h3,
		BMP_WAIT = 3'h2,
		BMP_GAP = 3'h6
	} bmp_state_t;

	typedef struct packed {
		logic grant_n;
		logic strobe_n;
		logic ack_low_n;
		logic ack_high_n;
		logic gack_n;
		logic sel_n;
		logic dir;
		logic [1:0] usr;
		logic [15:0] data;
	} bmp_pins_t;

	typedef struct packed {
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} bmp_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} bmp_apb_rsp_t;

	typedef struct packed {
		bmp_state_t state;
		bmp_pins_t s1;
		bmp_pins_t s2;
		logic [1:0] ack3;
		logic [15:0] data_config_register;
		logic [7:0] cnt_tgt;
		logic [7:0] cnt;
		logic mem_write;
		logic [31:0] addr;
		logic [1:0] cap_cnt;
		logic cap_done;
		logic req_oe;
		logic gack_oe;
		logic as_oe;
		logic rw_out;
		logic ack_oe;
		logic [31:0] dout;
		logic dout_oe;
		logic slv_busy;
		bmp_apb_rsp_t rsp;
	} bmp_st_t;

endpackage

// ### core/bmp_port.sv
// system bus port: arbitration, slave register access and acknowledge-terminated master cycles
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "bmp_regs.svh"

module bmp_port (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire bmp_pkg::bmp_apb_req_t apb_i,
	output bmp_pkg::bmp_apb_rsp_t apb_o,
	output logic request_out_o,
	output logic request_out_oe_o,
	input wire logic grant_in_n_i,
	input wire logic address_strobe_n_i,
	output logic address_strobe_n_o,
	output logic address_strobe_oe_o,
	input wire logic grant_acknowledge_n_i,
	output logic grant_acknowledge_n_o,
	output logic grant_acknowledge_oe_o,
	input wire logic width_ack_low_n_i,
	input wire logic width_ack_high_n_i,
	output logic width_ack_low_n_o,
	output logic width_ack_high_n_o,
	output logic width_ack_oe_o,
	input wire logic chip_select_n_i,
	input wire logic slave_direction_i,
	input wire logic [15:0] data_i,
	output logic [31:0] data_o,
	output logic data_oe_o,
	output logic [31:0] mem_addr_o,
	output logic mem_read_write_o,
	input wire logic user_pin_a_i,
	input wire logic user_pin_b_i,
	output logic user_pin_a_o,
	output logic user_pin_b_o,
	output logic user_pins_oe_o
);

	bmp_pkg::bmp_st_t q, d;
	bmp_pkg::bmp_pins_t pins;
	logic [1:0] ack_n;
	logic bus_free;
	logic ack_done;
	logic setup;
	logic access;
	logic [11:0] off;
	logic mapped;
	logic [31:0] rd;
	logic apb_ctrl_wr;
	logic apb_dcr_wr;
	// decoded conditions that the state record update reads
	logic apb_addr_wr;
	logic start_req;
	logic claim_ok;
	logic acks_off;
	logic last_cycle;
	logic [31:0] addr_step;
	logic slv_start;
	logic slv_end;

	always_comb begin
		pins.grant_n = grant_in_n_i;
		pins.strobe_n = address_strobe_n_i;
		pins.ack_low_n = width_ack_low_n_i;
		pins.ack_high_n = width_ack_high_n_i;
		pins.gack_n = grant_acknowledge_n_i;
		pins.sel_n = chip_select_n_i;
		pins.dir = slave_direction_i;
		pins.usr = {user_pin_b_i, user_pin_a_i};
		pins.data = data_i;
	end

	// async sampling adds a stage so a marginal edge gets extra settling time
	always_comb begin
		if (q.data_config_register[`BMP_DCR_SYNC]) begin
			ack_n = {q.s2.ack_high_n, q.s2.ack_low_n};
		end else begin
			ack_n = q.ack3;
		end
	end

	// our own strobe and acknowledge are not masked out: the strobe is never driven while idle, and the acknowledge only in a host access, which blocks the claim
	assign bus_free = !q.s2.grant_n
		&& q.s2.strobe_n
		&& q.s2.ack_low_n && q.s2.ack_high_n
		&& q.s2.gack_n;

	// user pins are outputs while we own the bus, so they must be captured first
	assign claim_ok = bus_free && !q.slv_busy && q.cap_done;

	// width comes only from the config register, never from which acknowledge arrived
	assign ack_done = q.data_config_register[`BMP_DCR_WIDTH32] ? (ack_n == 2'b00)
		: !ack_n[1];
	assign addr_step = q.data_config_register[`BMP_DCR_WIDTH32] ? 32'h0000_0004 : 32'h0000_0002;
	assign last_cycle = (q.cnt + 8'h01) == q.cnt_tgt;
	// a slave still holding an acknowledge would end our next cycle at once
	assign acks_off = (ack_n == 2'b11);

	assign setup = apb_i.psel && !apb_i.penable;
	assign access = apb_i.psel && apb_i.penable && q.rsp.pready;
	assign off = apb_i.paddr[11:0];
	// an unmapped offset answers with an error and changes nothing
	assign mapped = (off == `BMP_OFF_DCR) || (off == `BMP_OFF_CTRL)
		|| (off == `BMP_OFF_STAT) || (off == `BMP_OFF_ADDR);
	assign apb_dcr_wr = access && apb_i.pwrite && (off == `BMP_OFF_DCR);
	assign apb_ctrl_wr = access && apb_i.pwrite && (off == `BMP_OFF_CTRL);
	assign apb_addr_wr = access && apb_i.pwrite && (off == `BMP_OFF_ADDR);
	// a start with a zero count would claim the bus for nothing, so it is ignored
	assign start_req = apb_ctrl_wr && apb_i.pwdata[`BMP_CTRL_START]
		&& (apb_i.pwdata[`BMP_CTRL_CNT_LSB +: 8] != 8'h00);

	// a host access is seen only once the select is through both sync flops
	assign slv_start = !q.slv_busy && !q.s2.sel_n;
	assign slv_end = q.slv_busy && q.s2.sel_n;

	always_comb begin
		rd = 32'h0000_0000;
		case (off)
			`BMP_OFF_DCR: begin
				rd = {16'h0000, q.data_config_register};
			end
			`BMP_OFF_CTRL: begin
				// start reads back as zero: it is a strobe, not a setting
				rd[`BMP_CTRL_WRITE] = q.mem_write;
				rd[`BMP_CTRL_CNT_LSB +: 8] = q.cnt_tgt;
			end
			`BMP_OFF_STAT: begin
				rd[`BMP_STAT_REQ] = q.req_oe;
				rd[`BMP_STAT_MASTER] = q.gack_oe;
				rd[`BMP_STAT_BUSY] = (q.state != bmp_pkg::BMP_IDLE);
				rd[`BMP_STAT_CNT_LSB +: 8] = q.cnt;
			end
			`BMP_OFF_ADDR: begin
				rd = q.addr;
			end
			default: begin
				rd = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		d = q;
		// every pin passes two flops before any decision reads it
		d.s1 = pins;
		d.s2 = q.s1;
		d.ack3 = {q.s2.ack_high_n, q.s2.ack_low_n};

		// no wait state: the answer is registered in the cycle after setup
		d.rsp.pready = setup;
		d.rsp.pslverr = setup && !mapped;
		if (setup) begin
			d.rsp.prdata = apb_i.pwrite ? 32'h0000_0000 : rd;
		end

		// user pins are taken once the synchronised level is valid after release
		if (!q.cap_done) begin
			d.cap_cnt = q.cap_cnt + 2'h1;
			if (q.cap_cnt == `BMP_CAP_DELAY) begin
				d.cap_done = 1'b1;
				d.data_config_register[`BMP_DCR_USRIN_A] = q.s2.usr[0];
				d.data_config_register[`BMP_DCR_USRIN_B] = q.s2.usr[1];
			end
		end

		if (apb_dcr_wr) begin
			d.data_config_register = apb_i.pwdata[15:0] & `BMP_DCR_MASK;
		end
		if (apb_addr_wr) begin
			d.addr = apb_i.pwdata;
		end
		if (apb_ctrl_wr) begin
			d.mem_write = apb_i.pwdata[`BMP_CTRL_WRITE];
			d.cnt_tgt = apb_i.pwdata[`BMP_CTRL_CNT_LSB +: 8];
		end

		// slave access from the host pins; a config write from APB wins a collision
		if (slv_start) begin
			d.slv_busy = 1'b1;
			d.ack_oe = 1'b1;
			if (q.s2.dir) begin
				d.dout = {`BMP_MEAN_UPPER, q.data_config_register};
				d.dout_oe = 1'b1;
			end else if (!apb_dcr_wr) begin
				d.data_config_register = q.s2.data & `BMP_DCR_MASK;
			end
		end else if (slv_end) begin
			d.slv_busy = 1'b0;
			d.ack_oe = 1'b0;
			d.dout_oe = 1'b0;
		end

		case (q.state)
			bmp_pkg::BMP_IDLE: begin
				if (start_req) begin
					d.cnt = 8'h00;
					d.req_oe = 1'b1;
					d.state = bmp_pkg::BMP_REQ;
				end
			end
			bmp_pkg::BMP_REQ: begin
				// the request is withdrawn on the same edge that claims the bus
				if (claim_ok) begin
					d.req_oe = 1'b0;
					d.gack_oe = 1'b1;
					d.state = bmp_pkg::BMP_CYC;
				end
			end
			bmp_pkg::BMP_CYC: begin
				d.rw_out = !q.mem_write;
				d.as_oe = 1'b1;
				d.state = bmp_pkg::BMP_WAIT;
			end
			bmp_pkg::BMP_WAIT: begin
				if (ack_done) begin
					d.as_oe = 1'b0;
					d.cnt = q.cnt + 8'h01;
					d.addr = q.addr + addr_step;
					// grant acknowledge falls with the final acknowledge, not after it
					if (last_cycle) begin
						d.gack_oe = 1'b0;
					end
					d.state = bmp_pkg::BMP_GAP;
				end
			end
			bmp_pkg::BMP_GAP: begin
				// the slave must let go of both acknowledges before the next strobe
				if (acks_off) begin
					d.state = q.gack_oe ? bmp_pkg::BMP_CYC : bmp_pkg::BMP_IDLE;
				end
			end
			default: begin
				d.state = bmp_pkg::BMP_IDLE;
				d.req_oe = 1'b0;
				d.gack_oe = 1'b0;
				d.as_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// pin stages start at the released level so no false select follows reset
			q.state <= bmp_pkg::BMP_IDLE;
			q.s1 <= '1;
			q.s2 <= '1;
			q.ack3 <= 2'b11;
			q.data_config_register <= `BMP_DCR_RST;
			q.cnt_tgt <= 8'h00;
			q.cnt <= 8'h00;
			q.mem_write <= 1'b0;
			q.addr <= 32'h0000_0000;
			q.cap_cnt <= 2'h0;
			q.cap_done <= 1'b0;
			q.req_oe <= 1'b0;
			q.gack_oe <= 1'b0;
			q.as_oe <= 1'b0;
			q.rw_out <= 1'b1;
			q.ack_oe <= 1'b0;
			q.dout <= 32'h0000_0000;
			q.dout_oe <= 1'b0;
			q.slv_busy <= 1'b0;
			q.rsp <= '0;
		end else begin
			q <= d;
		end
	end

	// the control pins are open-drain style: their levels are fixed low and each enable is a register
	assign apb_o = q.rsp;
	assign request_out_o = 1'b0;
	assign request_out_oe_o = q.req_oe;
	assign address_strobe_n_o = 1'b0;
	assign address_strobe_oe_o = q.as_oe;
	assign grant_acknowledge_n_o = 1'b0;
	assign grant_acknowledge_oe_o = q.gack_oe;
	assign width_ack_low_n_o = 1'b0;
	assign width_ack_high_n_o = 1'b0;
	assign width_ack_oe_o = q.ack_oe;
	assign data_o = q.dout;
	assign data_oe_o = q.dout_oe;
	assign mem_addr_o = q.addr;
	assign mem_read_write_o = q.rw_out;
	assign user_pin_a_o = q.data_config_register[`BMP_DCR_USROUT_A];
	assign user_pin_b_o = q.data_config_register[`BMP_DCR_USROUT_B];
	assign user_pins_oe_o = q.gack_oe;

endmodule

// ### core/bmp_regs.svh
// register offsets, field positions, reset values and timing counts of the bus port
`ifndef BMP_REGS_SVH
`define BMP_REGS_SVH

`define BMP_OFF_DCR 12'h000
`define BMP_OFF_CTRL 12'h004
`define BMP_OFF_STAT 12'h008
`define BMP_OFF_ADDR 12'h00C

`define BMP_DCR_WIDTH32 5
`define BMP_DCR_USRIN_A 8
`define BMP_DCR_USRIN_B 9
`define BMP_DCR_SYNC 10
`define BMP_DCR_USROUT_A 11
`define BMP_DCR_USROUT_B 12
`define BMP_DCR_RST 16'h0000
`define BMP_DCR_MASK 16'h3FFF

`define BMP_CTRL_START 0
`define BMP_CTRL_WRITE 1
`define BMP_CTRL_CNT_LSB 8

`define BMP_STAT_REQ 0
`define BMP_STAT_MASTER 1
`define BMP_STAT_BUSY 2
`define BMP_STAT_CNT_LSB 8

`define BMP_CAP_DELAY 2'h2
`define BMP_MEAN_UPPER 16'h0000

`endif

// ### tb/bmp_partner.sv
// far side: bus arbiter and a memory slave ending cycles with width acknowledges
`timescale 1ns/1ns
module bmp_partner (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic strobe_i,
	input wire logic full_i,
	input wire logic slow_i,
	output logic grant_n_o,
	output logic ack_low_n_o,
	output logic ack_high_n_o
);
	logic [3:0] age_q;
	logic [3:0] due;
	assign due = slow_i ? 4'h4 : 4'h1;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			age_q <= 4'h0;
			grant_n_o <= 1'b1;
			ack_low_n_o <= 1'b1;
			ack_high_n_o <= 1'b1;
		end else begin
			grant_n_o <= !req_i;
			age_q <= strobe_i ? age_q + 4'h1 : 4'h0;
			ack_high_n_o <= !(strobe_i && age_q >= due);
			// low ack lags, so ending a wide cycle on the high ack alone shows
			ack_low_n_o <= !(strobe_i && full_i && age_q >= due + 4'h2);
		end
	end
endmodule

// ### tb/bmp_props.sv
// checker of the bus port's arbitration and slave acknowledge timing
`timescale 1ns/1ns
module bmp_props (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic request_out_oe_o,
	input wire logic grant_in_n_i,
	input wire logic address_strobe_n_i,
	input wire logic address_strobe_oe_o,
	input wire logic grant_acknowledge_n_i,
	input wire logic grant_acknowledge_oe_o,
	input wire logic width_ack_low_n_i,
	input wire logic width_ack_high_n_i,
	input wire logic width_ack_oe_o,
	input wire logic chip_select_n_i,
	input wire logic [31:0] data_o,
	input wire logic data_oe_o,
	input wire logic user_pins_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// pins pass two sync flops, so the claim looks at them three edges back
	sequence s_claim;
		$rose(grant_acknowledge_oe_o);
	endsequence
	a_req_handover: assert property ($fell(request_out_oe_o) |-> grant_acknowledge_oe_o)
		else $error("request dropped without claim");
	a_claim_grant: assert property (s_claim |-> !$past(grant_in_n_i, 3))
		else $error("claim without grant");
	a_claim_strobe: assert property (s_claim |-> $past(address_strobe_n_i, 3))
		else $error("claim while strobe busy");
	a_claim_acks: assert property (s_claim |->
		$past(width_ack_low_n_i, 3) && $past(width_ack_high_n_i, 3))
		else $error("claim while acks busy");
	a_claim_wire: assert property (s_claim |-> $past(grant_acknowledge_n_i, 3))
		else $error("claim while other owner");
	a_slave_ack: assert property ($rose(width_ack_oe_o) |-> !$past(chip_select_n_i, 3))
		else $error("slave ack without select");
	a_read_upper: assert property (data_oe_o |-> width_ack_oe_o && data_o[31:16] == 16'h0000)
		else $error("bad read drive");
	a_strobe_ack: assert property ($fell(address_strobe_oe_o) |-> !$past(width_ack_high_n_i, 3))
		else $error("cycle ended without ack");
	a_user_owner: assert property (user_pins_oe_o |-> grant_acknowledge_oe_o)
		else $error("user pins driven off bus");
endmodule
bind bmp_port bmp_props u_props (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.request_out_oe_o(request_out_oe_o),
	.grant_in_n_i(grant_in_n_i),
	.address_strobe_n_i(address_strobe_n_i),
	.address_strobe_oe_o(address_strobe_oe_o),
	.grant_acknowledge_n_i(grant_acknowledge_n_i),
	.grant_acknowledge_oe_o(grant_acknowledge_oe_o),
	.width_ack_low_n_i(width_ack_low_n_i),
	.width_ack_high_n_i(width_ack_high_n_i),
	.width_ack_oe_o(width_ack_oe_o),
	.chip_select_n_i(chip_select_n_i),
	.data_o(data_o),
	.data_oe_o(data_oe_o),
	.user_pins_oe_o(user_pins_oe_o)
);

// ### tb/tb_top.sv
// testbench of the bus port: registers, mastership bursts and host slave access
`timescale 1ns/1ns
`include "bmp_regs.svh"
module tb_top;
	typedef struct packed {
		logic [31:0] val;
		logic [31:0] mask;
		logic err;
	} bmp_note_t;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	bmp_pkg::bmp_apb_req_t apb_i = '0;
	bmp_pkg::bmp_apb_rsp_t apb_o;
	logic request_out_o, request_out_oe_o, address_strobe_n_o, address_strobe_oe_o;
	logic grant_acknowledge_n_o, grant_acknowledge_oe_o, width_ack_low_n_o;
	logic width_ack_high_n_o, width_ack_oe_o, data_oe_o, mem_read_write_o;
	logic user_pin_a_o, user_pin_b_o, user_pins_oe_o, grant_in_n_i, p_lo_n, p_hi_n;
	logic chip_select_n_i = 1'b1;
	logic slave_direction_i = 1'b0;
	logic pin_a = 1'b1;
	logic pin_b = 1'b1;
	logic m = 1'b0;
	logic [15:0] data_i = 16'h0000;
	logic [31:0] data_o, mem_addr_o, v, d;
	logic [31:0] seed = 32'h0000_1fec;
	int errors = 0;
	int samples_checked = 0;
	bmp_note_t q[$];
	bmp_note_t nt;
	wire address_strobe_n_i = !address_strobe_oe_o;
	wire grant_acknowledge_n_i = !grant_acknowledge_oe_o;
	wire width_ack_low_n_i = !width_ack_oe_o && p_lo_n;
	wire width_ack_high_n_i = !width_ack_oe_o && p_hi_n;
	wire user_pin_a_i = user_pins_oe_o ? user_pin_a_o : pin_a;
	wire user_pin_b_i = user_pins_oe_o ? user_pin_b_o : pin_b;
	bmp_port uut (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.apb_i(apb_i),
		.apb_o(apb_o),
		.request_out_o(request_out_o),
		.request_out_oe_o(request_out_oe_o),
		.grant_in_n_i(grant_in_n_i),
		.address_strobe_n_i(address_strobe_n_i),
		.address_strobe_n_o(address_strobe_n_o),
		.address_strobe_oe_o(address_strobe_oe_o),
		.grant_acknowledge_n_i(grant_acknowledge_n_i),
		.grant_acknowledge_n_o(grant_acknowledge_n_o),
		.grant_acknowledge_oe_o(grant_acknowledge_oe_o),
		.width_ack_low_n_i(width_ack_low_n_i),
		.width_ack_high_n_i(width_ack_high_n_i),
		.width_ack_low_n_o(width_ack_low_n_o),
		.width_ack_high_n_o(width_ack_high_n_o),
		.width_ack_oe_o(width_ack_oe_o),
		.chip_select_n_i(chip_select_n_i),
		.slave_direction_i(slave_direction_i),
		.data_i(data_i),
		.data_o(data_o),
		.data_oe_o(data_oe_o),
		.mem_addr_o(mem_addr_o),
		.mem_read_write_o(mem_read_write_o),
		.user_pin_a_i(user_pin_a_i),
		.user_pin_b_i(user_pin_b_i),
		.user_pin_a_o(user_pin_a_o),
		.user_pin_b_o(user_pin_b_o),
		.user_pins_oe_o(user_pins_oe_o)
	);
	bmp_partner far (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.req_i(request_out_oe_o),
		.strobe_i(address_strobe_oe_o),
		.full_i(m),
		.slow_i(mem_read_write_o),
		.grant_n_o(grant_in_n_i),
		.ack_low_n_o(p_lo_n),
		.ack_high_n_o(p_hi_n)
	);
	always #25 clk_i = ~clk_i;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic sig(input int k);
		case (k)
			0: return apb_o.pready;
			1: return grant_acknowledge_oe_o;
			2: return address_strobe_oe_o;
			default: return width_ack_oe_o;
		endcase
	endfunction
	task automatic summarize();
		if (errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			$display("unexpected %s exp %h got %h", nm, e, s);
			errors++;
		end
	endtask
	task automatic wt(input int k, input logic lv);
		int n;
		n = 0;
		while (sig(k) !== lv) begin
			@(posedge clk_i);
			n++;
			if (n > 400) begin
				$display("unexpected wait %0d exp %b got %b", k, lv, sig(k));
				errors++;
				summarize();
			end
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, e, mk);
		@(posedge clk_i);
		q.push_back('{e, mk, a[11:0] > 12'h00C});
		apb_i <= '{a, 1'b1, 1'b0, w, e};
		@(posedge clk_i);
		apb_i.penable <= 1'b1;
		wt(0, 1'b1);
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask
	always @(posedge clk_i) begin
		if (apb_o.pready === 1'b1 && q.size() > 0) begin
			nt = q.pop_front();
			chk("prdata", nt.val & nt.mask, apb_o.prdata & nt.mask);
			chk("pslverr", 32'(nt.err), 32'(apb_o.pslverr));
		end
	end
	initial begin
		d = xs();
		pin_a = d[0];
		pin_b = d[1];
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		apb(0, `BMP_OFF_DCR, 32'({pin_b, pin_a}) << 8, 32'h0000_ffff);
		apb(0, 32'h0000_0010, 0, 0);
		for (int i = 0; i < 2; i++) begin
			m <= i[0];
			v = 32'({i[0], !i[0], i[0], pin_b, pin_a, 2'h0, i[0], 5'h00});
			apb(1, `BMP_OFF_DCR, v, 0);
			apb(0, `BMP_OFF_DCR, v, 32'h0000_ffff);
			apb(1, `BMP_OFF_ADDR, 32'h0000_0100, 0);
			apb(1, `BMP_OFF_CTRL, 32'h0000_0301 | 32'(m) << 1, 0);
			wt(1, 1'b1);
			chk("user", 32'({1'b1, m, !m}), 32'({user_pins_oe_o, user_pin_b_o, user_pin_a_o}));
			chk("lows", 0, 32'({request_out_o, address_strobe_n_o, grant_acknowledge_n_o}));
			chk("acklow", 0, 32'({width_ack_low_n_o, width_ack_high_n_o}));
			wt(2, 1'b1);
			chk("dir", 32'(!m), 32'(mem_read_write_o));
			wt(1, 1'b0);
			// busy stays up until the released acknowledges are through the sync flops
			repeat (4) @(posedge clk_i);
			apb(0, `BMP_OFF_STAT, 32'h0000_0300, 32'h0000_ff07);
			chk("addr", 32'h0000_0100 + (m ? 12 : 6), mem_addr_o);
		end
		slave_direction_i <= 1'b1;
		chip_select_n_i <= 1'b0;
		wt(3, 1'b1);
		chk("rdata", {16'h0000, v[15:0]}, data_o);
		chk("rdoe", 32'h0000_0001, 32'(data_oe_o));
		chip_select_n_i <= 1'b1;
		wt(3, 1'b0);
		d = xs();
		data_i <= d[15:0];
		slave_direction_i <= 1'b0;
		chip_select_n_i <= 1'b0;
		wt(3, 1'b1);
		chip_select_n_i <= 1'b1;
		wt(3, 1'b0);
		apb(0, `BMP_OFF_DCR, d & 32'h0000_3fff, 32'h0000_ffff);
		summarize();
	end
endmodule
